// *** logic/ext_bus_glue_pkg.sv ***
// Constants and types shared by the external bus card and flash glue.
// Assumes a 32-bit system address and active-low strobes from the static memory controller.
package ext_bus_glue_pkg;

  // ------------------------------------------------------------------
  // Address windows and fields
  // ------------------------------------------------------------------
  localparam int ADDR_WIDTH = 32;
  localparam int WINDOW_MSB = 31;
  localparam int WINDOW_LSB = 28;
  localparam int MODE_MSB = 23;
  localparam int MODE_LSB = 21;
  localparam int REG_SEL_BIT = 22;
  localparam logic [3:0] FLASH_WINDOW = 4'h4;
  localparam logic [3:0] SLOT0_WINDOW = 4'h5;
  localparam logic [3:0] SLOT1_WINDOW = 4'h6;

  // ------------------------------------------------------------------
  // Card mode codes on address bits 23:21
  // ------------------------------------------------------------------
  localparam logic [2:0] CODE_ATTR = 3'h0;
  localparam logic [2:0] CODE_COMMON = 3'h2;
  localparam logic [2:0] CODE_IO = 3'h4;
  localparam logic [2:0] CODE_TIDE = 3'h6;
  localparam logic [2:0] CODE_ALT_TIDE = 3'h7;

  // ------------------------------------------------------------------
  // Values after reset (all strobes inactive high)
  // ------------------------------------------------------------------
  localparam logic STROBE_IDLE = 1'b1;
  localparam logic A25_RESET = 1'b0;
  localparam logic [2:0] MODE_STATUS_RESET = 3'h0;

  typedef enum logic [2:0] {
    MODE_NONE,
    MODE_ATTR,
    MODE_COMMON,
    MODE_IO,
    MODE_TIDE,
    MODE_ALT_TIDE
  } card_mode_t;

endpackage

// *** logic/card_mode_decode.sv ***
// Combinational window and card-mode decoder for the external bus glue.
// Assumes the address is the current external transfer address.
`timescale 1ns/1ns
module card_mode_decode (
  // Transfer address
  input wire logic [ext_bus_glue_pkg::ADDR_WIDTH-1:0] i_addr,
  // Chip-select assignment bits
  input wire logic i_cs3_flash_assign,
  input wire logic i_cs4_card_assign,
  input wire logic i_cs5_card_assign,
  // Decoded windows and mode
  output logic o_flash_hit,
  output logic o_slot0_hit,
  output logic o_slot1_hit,
  output ext_bus_glue_pkg::card_mode_t o_mode
);
  import ext_bus_glue_pkg::*;

  logic [3:0] window;
  logic [2:0] code;

  // Window hits gated by assignment bits
  assign window = i_addr[WINDOW_MSB:WINDOW_LSB];
  assign code = i_addr[MODE_MSB:MODE_LSB];
  assign o_flash_hit = i_cs3_flash_assign && (window == FLASH_WINDOW);
  assign o_slot0_hit = i_cs4_card_assign && (window == SLOT0_WINDOW);
  assign o_slot1_hit = i_cs5_card_assign && (window == SLOT1_WINDOW);

  // Mode from address bits 23:21; unused codes decode to no mode
  always_comb begin
    o_mode = MODE_NONE;
    if (o_slot0_hit || o_slot1_hit) begin
      case (code)
        CODE_ATTR: o_mode = MODE_ATTR;
        CODE_COMMON: o_mode = MODE_COMMON;
        CODE_IO: o_mode = MODE_IO;
        CODE_TIDE: o_mode = MODE_TIDE;
        CODE_ALT_TIDE: o_mode = MODE_ALT_TIDE;
        default: o_mode = MODE_NONE;
      endcase
    end
  end

endmodule // card_mode_decode

// *** logic/ext_bus_glue.sv ***
// Top of the external bus glue: card slot and raw flash pin multiplexing.
// Assumes static memory controller strobes synchronous to i_clk, all active low,
// and per-chip-select width and access-mode bits supplied as plain inputs.
`timescale 1ns/1ns
module ext_bus_glue #(
  parameter int ADDR_W = ext_bus_glue_pkg::ADDR_WIDTH
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Transfer from the static memory controller
  input wire logic [ext_bus_glue_pkg::ADDR_WIDTH-1:0] i_addr,
  input wire logic i_access_active,
  input wire logic i_read_not_write,
  input wire logic i_chip_select_three_n,
  input wire logic i_chip_select_four_n,
  input wire logic i_chip_select_five_n,
  input wire logic i_read_strobe_n,
  input wire logic i_write_strobe_lane0_n,
  input wire logic i_write_strobe_lane1_n,
  input wire logic i_write_strobe_lane3_n,
  input wire logic i_byte_lane0_select_n,
  input wire logic i_byte_lane1_select_n,
  // Per chip-select configuration
  input wire logic i_cs4_byte_select_mode,
  input wire logic i_cs5_byte_select_mode,
  input wire logic i_cs4_width16,
  input wire logic i_cs5_width16,
  // Assignment and card control
  input wire logic i_cs3_flash_assign,
  input wire logic i_cs4_card_assign,
  input wire logic i_cs5_card_assign,
  input wire logic i_card_standby,
  input wire logic i_external_wait_in_n,
  // Chip-select pins
  output logic o_chip_select_three_n,
  output logic o_cs4_pin_n,
  output logic o_cs5_pin_n,
  // Shared strobe pins
  output logic o_rd_pin_n,
  output logic o_wr0_pin_n,
  output logic o_wr1_pin_n,
  output logic o_wr3_pin_n,
  output logic o_a25_pin,
  // Dedicated card pins
  output logic o_card_enable_lo_n,
  output logic o_card_enable_hi_n,
  output logic o_card_reg_n,
  // Flash pins
  output logic o_flash_output_enable_n,
  output logic o_flash_write_enable_n,
  // Wait back to the controller and status
  output logic o_smc_wait_n,
  output logic o_card_access,
  output logic o_flash_access,
  output logic [2:0] o_card_mode
);
  import ext_bus_glue_pkg::*;

  // ------------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------------
  if (ADDR_W != ADDR_WIDTH) begin : g_bad_width
    $error("ext_bus_glue needs a 32-bit address");
  end

  // ------------------------------------------------------------------
  // State of the block
  // ------------------------------------------------------------------
  typedef struct packed {
    logic cs3_n;
    logic cs4_n;
    logic cs5_n;
    logic rd_n;
    logic wr0_n;
    logic wr1_n;
    logic wr3_n;
    logic a25;
    logic ce_lo_n;
    logic ce_hi_n;
    logic reg_n;
    logic foe_n;
    logic fwe_n;
    logic wait_n;
    logic card_acc;
    logic flash_acc;
    logic [2:0] mode;
  } glue_state_t;

  glue_state_t state_q;
  glue_state_t state_d;

  logic flash_hit;
  logic slot0_hit;
  logic slot1_hit;
  card_mode_t mode;

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  card_mode_decode u_decode (
    .i_addr(i_addr),
    .i_cs3_flash_assign(i_cs3_flash_assign),
    .i_cs4_card_assign(i_cs4_card_assign),
    .i_cs5_card_assign(i_cs5_card_assign),
    .o_flash_hit(flash_hit),
    .o_slot0_hit(slot0_hit),
    .o_slot1_hit(slot1_hit),
    .o_mode(mode)
  );

  // ------------------------------------------------------------------
  // Per-access selection of the owning chip select
  // ------------------------------------------------------------------
  logic owner_cs_n;
  logic owner_byte_sel;
  logic owner_wide;
  logic card_acc;
  logic flash_acc;
  logic bs0_n;
  logic bs1_n;
  logic mem_mode;
  logic io_mode;

  // Owning chip select of the card window and its configuration
  always_comb begin
    owner_cs_n = STROBE_IDLE;
    owner_byte_sel = 1'b0;
    owner_wide = 1'b0;
    if (slot0_hit) begin
      owner_cs_n = i_chip_select_four_n;
      owner_byte_sel = i_cs4_byte_select_mode;
      owner_wide = i_cs4_width16;
    end else if (slot1_hit) begin
      owner_cs_n = i_chip_select_five_n;
      owner_byte_sel = i_cs5_byte_select_mode;
      owner_wide = i_cs5_width16;
    end
  end

  // Card access needs a valid mode, no standby and an active transfer
  assign card_acc = i_access_active && !i_card_standby && (mode != MODE_NONE) && !owner_cs_n;
  assign flash_acc = i_access_active && flash_hit && !i_chip_select_three_n;

  // Byte selects count only in byte-select access mode
  assign bs0_n = owner_byte_sel ? i_byte_lane0_select_n : STROBE_IDLE;
  assign bs1_n = owner_byte_sel ? i_byte_lane1_select_n : STROBE_IDLE;

  // Mode classes for strobe routing
  assign mem_mode = (mode == MODE_ATTR) || (mode == MODE_COMMON);
  assign io_mode = (mode == MODE_IO) || (mode == MODE_TIDE) || (mode == MODE_ALT_TIDE);

  // ------------------------------------------------------------------
  // Card enables
  // ------------------------------------------------------------------
  logic ce_lo_n;
  logic ce_hi_n;

  // Enables track the owning chip select, qualified by mode and width
  always_comb begin
    ce_lo_n = STROBE_IDLE;
    ce_hi_n = STROBE_IDLE;
    if (card_acc) begin
      case (mode)
        MODE_ATTR: begin
          ce_hi_n = owner_cs_n | bs1_n;
          ce_lo_n = owner_cs_n | bs0_n;
        end
        MODE_COMMON, MODE_IO: begin
          if (owner_wide) begin
            ce_hi_n = owner_cs_n | bs1_n;
            ce_lo_n = owner_cs_n | bs0_n;
          end else begin
            ce_hi_n = 1'b1;
            ce_lo_n = owner_cs_n;
          end
        end
        MODE_TIDE: begin
          ce_hi_n = 1'b1;
          ce_lo_n = owner_cs_n;
        end
        MODE_ALT_TIDE: begin
          ce_hi_n = owner_cs_n;
          ce_lo_n = 1'b1;
        end
        default: begin
          ce_hi_n = STROBE_IDLE;
          ce_lo_n = STROBE_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Card read and write strobes
  // ------------------------------------------------------------------
  logic card_oe_n;
  logic card_we_n;
  logic card_ior_n;
  logic card_iow_n;

  // Memory modes use OE/WE, IO and IDE modes use IOR/IOW
  always_comb begin
    card_oe_n = STROBE_IDLE;
    card_we_n = STROBE_IDLE;
    card_ior_n = STROBE_IDLE;
    card_iow_n = STROBE_IDLE;
    if (card_acc && mem_mode) begin
      card_oe_n = i_read_strobe_n;
      card_we_n = i_write_strobe_lane0_n;
    end else if (card_acc && io_mode) begin
      card_ior_n = i_read_strobe_n;
      card_iow_n = i_write_strobe_lane0_n;
      if (mode != MODE_IO) begin
        card_oe_n = 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Next state: pin multiplexing
  // ------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.card_acc = card_acc;
    state_d.flash_acc = flash_acc;
    state_d.mode = card_acc ? 3'(mode) : MODE_STATUS_RESET;
    state_d.cs3_n = i_chip_select_three_n;
    // Chip-select pins carry slot select when assigned
    state_d.cs4_n = i_cs4_card_assign ? i_chip_select_four_n : i_chip_select_four_n;
    if (i_cs4_card_assign) begin
      state_d.cs4_n = i_chip_select_four_n | i_card_standby;
    end
    state_d.cs5_n = i_chip_select_five_n;
    if (i_cs5_card_assign) begin
      state_d.cs5_n = i_chip_select_five_n | i_card_standby;
    end
    state_d.ce_lo_n = ce_lo_n;
    state_d.ce_hi_n = ce_hi_n;
    // Register select from address bit 22, unused in True IDE but still driven in alternate True IDE
    state_d.reg_n = (card_acc && mode != MODE_TIDE) ? i_addr[REG_SEL_BIT] : STROBE_IDLE;
    // Shared pins: card signals on card accesses, plain ones otherwise
    if (card_acc) begin
      state_d.rd_n = card_oe_n;
      state_d.wr0_n = card_we_n;
      state_d.wr1_n = card_ior_n;
      state_d.wr3_n = card_iow_n;
      state_d.a25 = i_read_not_write;
    end else if (i_access_active) begin
      state_d.rd_n = i_read_strobe_n;
      state_d.wr0_n = i_write_strobe_lane0_n;
      state_d.wr1_n = i_write_strobe_lane1_n;
      state_d.wr3_n = i_write_strobe_lane3_n;
      state_d.a25 = i_addr[25];
    end else begin
      // Idle: strobes inactive, address-like pin held stable
      state_d.rd_n = STROBE_IDLE;
      state_d.wr0_n = STROBE_IDLE;
      state_d.wr1_n = STROBE_IDLE;
      state_d.wr3_n = STROBE_IDLE;
    end
    // Flash strobes only while chip select 3 is inside its window
    state_d.foe_n = flash_acc ? i_read_strobe_n : STROBE_IDLE;
    state_d.fwe_n = flash_acc ? i_write_strobe_lane0_n : STROBE_IDLE;
    // Card wait passes back to the controller only during card accesses
    state_d.wait_n = card_acc ? i_external_wait_in_n : STROBE_IDLE;
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q <= '{cs3_n: STROBE_IDLE, cs4_n: STROBE_IDLE, cs5_n: STROBE_IDLE,
                   rd_n: STROBE_IDLE, wr0_n: STROBE_IDLE, wr1_n: STROBE_IDLE, wr3_n: STROBE_IDLE,
                   a25: A25_RESET, ce_lo_n: STROBE_IDLE, ce_hi_n: STROBE_IDLE, reg_n: STROBE_IDLE,
                   foe_n: STROBE_IDLE, fwe_n: STROBE_IDLE, wait_n: STROBE_IDLE,
                   card_acc: 1'b0, flash_acc: 1'b0, mode: MODE_STATUS_RESET};
    end else begin
      state_q <= state_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs, straight from the state register
  // ------------------------------------------------------------------
  assign o_chip_select_three_n = state_q.cs3_n;
  assign o_cs4_pin_n = state_q.cs4_n;
  assign o_cs5_pin_n = state_q.cs5_n;
  assign o_rd_pin_n = state_q.rd_n;
  assign o_wr0_pin_n = state_q.wr0_n;
  assign o_wr1_pin_n = state_q.wr1_n;
  assign o_wr3_pin_n = state_q.wr3_n;
  assign o_a25_pin = state_q.a25;
  assign o_card_enable_lo_n = state_q.ce_lo_n;
  assign o_card_enable_hi_n = state_q.ce_hi_n;
  assign o_card_reg_n = state_q.reg_n;
  assign o_flash_output_enable_n = state_q.foe_n;
  assign o_flash_write_enable_n = state_q.fwe_n;
  assign o_smc_wait_n = state_q.wait_n;
  assign o_card_access = state_q.card_acc;
  assign o_flash_access = state_q.flash_acc;
  assign o_card_mode = state_q.mode;

endmodule // ext_bus_glue

// *** dv/ext_bus_glue_properties.sv ***
// Concurrent checks on the external bus glue pins.
// Assumes one clock, sync reset, every output one cycle behind its inputs.
`timescale 1ns/1ns
module ext_bus_glue_chk #(
  parameter int ADDR_W = ext_bus_glue_pkg::ADDR_WIDTH
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [ext_bus_glue_pkg::ADDR_WIDTH-1:0] i_addr,
  input wire logic i_access_active,
  input wire logic i_read_not_write,
  input wire logic i_chip_select_three_n,
  input wire logic i_chip_select_four_n,
  input wire logic i_read_strobe_n,
  input wire logic i_write_strobe_lane0_n,
  input wire logic i_cs3_flash_assign,
  input wire logic i_cs4_card_assign,
  input wire logic i_cs5_card_assign,
  input wire logic i_card_standby,
  input wire logic o_cs4_pin_n,
  input wire logic o_rd_pin_n,
  input wire logic o_wr0_pin_n,
  input wire logic o_wr1_pin_n,
  input wire logic o_wr3_pin_n,
  input wire logic o_a25_pin,
  input wire logic o_card_enable_lo_n,
  input wire logic o_card_enable_hi_n,
  input wire logic o_card_reg_n,
  input wire logic o_flash_output_enable_n,
  input wire logic o_flash_write_enable_n,
  input wire logic o_card_access,
  input wire logic [2:0] o_card_mode
);
  // Flash window hit as the controller presents it
  logic flash_hit;
  assign flash_hit = i_cs3_flash_assign && i_addr[31:28] == 4'h4 && !i_chip_select_three_n && i_access_active;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  chk_idle_strobes: assert property (!$past(i_access_active) |->
    o_rd_pin_n && o_wr0_pin_n && o_wr1_pin_n && o_wr3_pin_n) else $error("strobe active while idle");
  chk_unassigned_ce: assert property (!$past(i_cs4_card_assign) && !$past(i_cs5_card_assign) |->
    o_card_enable_lo_n && o_card_enable_hi_n) else $error("card enable without assignment");
  chk_standby_ce: assert property ($past(i_card_standby) |->
    o_card_enable_lo_n && o_card_enable_hi_n && !o_card_access) else $error("card enable in standby");
  chk_flash_route: assert property (!$past(i_srst) && $past(flash_hit) |->
    o_flash_output_enable_n == $past(i_read_strobe_n) && o_flash_write_enable_n == $past(i_write_strobe_lane0_n))
    else $error("flash strobes not routed");
  chk_flash_off: assert property (!$past(flash_hit) |->
    o_flash_output_enable_n && o_flash_write_enable_n) else $error("flash strobe outside window");
  chk_cs4_plain: assert property (!$past(i_srst) && !$past(i_cs4_card_assign) |->
    o_cs4_pin_n == $past(i_chip_select_four_n)) else $error("plain chip select 4 wrong");
  chk_slot0_select: assert property (!$past(i_srst) && $past(i_cs4_card_assign) |->
    o_cs4_pin_n == ($past(i_chip_select_four_n) | $past(i_card_standby))) else $error("slot 0 select wrong");
  chk_card_rnw: assert property (o_card_access |-> o_a25_pin == $past(i_read_not_write))
    else $error("direction pin wrong in card access");
  chk_ide_pins: assert property (o_card_mode == 3'h4 |-> !o_rd_pin_n && o_card_reg_n)
    else $error("ide mode pins wrong");
  chk_mem_io_off: assert property (o_card_mode inside {3'h1, 3'h2} |-> o_wr1_pin_n && o_wr3_pin_n)
    else $error("io strobes active in memory mode");
  // Main scenarios reached
  cov_ide: cover property (o_card_mode == 3'h4);
  cov_flash: cover property ($past(flash_hit) && !o_flash_write_enable_n);
  cov_standby: cover property ($past(i_card_standby) && $past(i_cs4_card_assign));
endmodule // ext_bus_glue_chk

bind ext_bus_glue ext_bus_glue_chk #(.ADDR_W(ADDR_W)) i_ext_bus_glue_chk (
  .i_clk, .i_srst, .i_addr, .i_access_active, .i_read_not_write, .i_chip_select_three_n,
  .i_chip_select_four_n, .i_read_strobe_n, .i_write_strobe_lane0_n, .i_cs3_flash_assign,
  .i_cs4_card_assign, .i_cs5_card_assign, .i_card_standby, .o_cs4_pin_n, .o_rd_pin_n,
  .o_wr0_pin_n, .o_wr1_pin_n, .o_wr3_pin_n, .o_a25_pin, .o_card_enable_lo_n, .o_card_enable_hi_n,
  .o_card_reg_n, .o_flash_output_enable_n, .o_flash_write_enable_n, .o_card_access, .o_card_mode
);

// *** dv/card_slot_model.sv ***
// Far-side model: card slot wait line and flash board wiring.
// Assumes card enables from the glue; wait line has a pull-up.
`timescale 1ns/1ns
module card_slot_model (
  // Clock and slot pins
  input wire logic i_clk,
  input wire logic i_ce_lo_n,
  input wire logic i_ce_hi_n,
  input wire logic i_slow,
  input wire logic [31:0] i_addr,
  // Answers
  output logic o_wait_n,
  output logic o_cmd_latch,
  output logic o_addr_latch,
  output logic o_flash_ce_n
);
  logic [1:0] cnt_q;
  // Cycles since the card was selected
  always_ff @(posedge i_clk) begin
    if (i_ce_lo_n && i_ce_hi_n) cnt_q <= 2'h0;
    else if (cnt_q != 2'h3) cnt_q <= cnt_q + 2'h1;
  end
  // Slow card holds wait for three cycles; deselected line floats to the pull-up
  assign o_wait_n = (i_ce_lo_n && i_ce_hi_n) || !i_slow || cnt_q == 2'h3;
  // Latch enables come straight from the address lines
  assign o_cmd_latch = i_addr[22];
  assign o_addr_latch = i_addr[21];
  // Flash enable kept low between accesses so the part never drops to standby
  assign o_flash_ce_n = 1'b0;
endmodule // card_slot_model

// *** dv/ext_bus_glue_tb.sv ***
// Self-checking bench for the external bus glue.
// Assumes the glue package and the card slot model are compiled first.
`timescale 1ns/1ns
module ext_bus_glue_tb;
  logic i_clk, i_srst, slow, a25_q;
  wire logic a25, wt;
  logic [31:0] i_addr, rnd;
  logic [18:0] c;
  wire logic [17:0] obs;
  int failures, samples_checked;
  // ------------------------------------------------------------------
  // Design and far side
  // ------------------------------------------------------------------
  ext_bus_glue i_ext_bus_glue (
    .i_clk, .i_srst, .i_addr, .i_access_active(c[0]), .i_read_not_write(c[1]),
    .i_chip_select_three_n(c[2]), .i_chip_select_four_n(c[3]), .i_chip_select_five_n(c[4]),
    .i_read_strobe_n(c[5]), .i_write_strobe_lane0_n(c[6]), .i_write_strobe_lane1_n(c[7]),
    .i_write_strobe_lane3_n(c[8]), .i_byte_lane0_select_n(c[9]), .i_byte_lane1_select_n(c[10]),
    .i_cs4_byte_select_mode(c[11]), .i_cs5_byte_select_mode(c[12]), .i_cs4_width16(c[13]),
    .i_cs5_width16(c[14]), .i_cs3_flash_assign(c[15]), .i_cs4_card_assign(c[16]),
    .i_cs5_card_assign(c[17]), .i_card_standby(c[18]), .i_external_wait_in_n(wt),
    .o_chip_select_three_n(obs[17]), .o_cs4_pin_n(obs[16]), .o_cs5_pin_n(obs[15]), .o_rd_pin_n(obs[14]),
    .o_wr0_pin_n(obs[13]), .o_wr1_pin_n(obs[12]), .o_wr3_pin_n(obs[11]), .o_a25_pin(a25),
    .o_card_enable_lo_n(obs[10]), .o_card_enable_hi_n(obs[9]), .o_card_reg_n(obs[8]),
    .o_flash_output_enable_n(obs[7]), .o_flash_write_enable_n(obs[6]), .o_smc_wait_n(obs[5]),
    .o_card_access(obs[4]), .o_flash_access(obs[3]), .o_card_mode(obs[2:0]));
  card_slot_model i_card_slot_model (.i_clk, .i_ce_lo_n(obs[10]), .i_ce_hi_n(obs[9]), .i_slow(slow),
    .i_addr, .o_wait_n(wt), .o_cmd_latch(), .o_addr_latch(), .o_flash_ce_n());
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Pins expected one cycle after address a and controls k
  function automatic logic [17:0] expect_pins(input logic [31:0] a, input logic [18:0] k, input logic w);
    logic s0, s1, card, fl, bm, hi, lo;
    logic [3:0] st;
    logic [2:0] m;
    s0 = k[16] && a[31:28] == 4'h5;
    s1 = k[17] && a[31:28] == 4'h6;
    m = a[23:21] == 3'h0 ? 3'h1 : a[23:21] == 3'h2 ? 3'h2 : a[23:21] == 3'h4 ? 3'h3 :
        a[23:21] == 3'h6 ? 3'h4 : a[23:21] == 3'h7 ? 3'h5 : 3'h0;
    bm = s0 ? k[11] : k[12];
    card = (s0 | s1) && m != 3'h0 && !k[18] && !(s0 ? k[3] : k[4]) && k[0];
    m = card ? m : 3'h0;
    {hi, lo} = 2'h3;
    if (m == 3'h1 || ((m == 3'h2 || m == 3'h3) && (s0 ? k[13] : k[14]))) {hi, lo} = {k[10] | !bm, k[9] | !bm};
    else if (m == 3'h2 || m == 3'h3 || m == 3'h4) {hi, lo} = 2'h2;
    else if (m == 3'h5) {hi, lo} = 2'h1;
    st = !k[0] ? 4'hF : m == 3'h0 ? {k[5], k[6], k[7], k[8]} : m < 3'h3 ? {k[5], k[6], 2'h3} :
         {m == 3'h3, 1'b1, k[5], k[6]};
    fl = k[15] && a[31:28] == 4'h4 && !k[2] && k[0];
    return {k[2], k[3] | (k[16] & k[18]), k[4] | (k[17] & k[18]), st, lo, hi, card && m != 3'h4 ? a[22] : 1'b1,
            fl ? k[5] : 1'b1, fl ? k[6] : 1'b1, card ? w : 1'b1, card, fl, m};
  endfunction
  // Drive one transfer cycle, then compare the pins one edge later
  task automatic step(input logic [31:0] a, input logic [18:0] k);
    logic [17:0] e;
    i_addr = a;
    c = k;
    @(posedge i_clk);
    e = expect_pins(a, k, wt);
    a25_q = e[4] ? k[1] : k[0] ? a[25] : a25_q;
    #1;
    samples_checked++;
    if (obs !== e || a25 !== a25_q) begin
      failures++;
      $display("[ERR] pins expected %h/%b seen %h/%b", e, a25_q, obs, a25);
    end
  endtask
  // Outputs must show their reset values whatever the inputs carry
  task automatic check_reset();
    a25_q = 1'b0;
    samples_checked++;
    if (obs !== 18'h3FFE0 || a25 !== 1'b0) begin
      failures++;
      $display("[ERR] reset pins expected %h/%b seen %h/%b", 18'h3FFE0, 1'b0, obs, a25);
    end
  endtask
  task automatic final_report();
    if (failures == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    #1000000;
    failures++;
    final_report();
  end
  initial begin
    failures = 0;
    samples_checked = 0;
    a25_q = 1'b0;
    slow = 1'b0;
    rnd = 32'h0000F544;
    i_addr = 32'h0;
    c = 19'h007FC;
    i_srst = 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    check_reset();
    i_srst = 1'b0;
    // Every mode code on slot 1 at both widths
    for (int i = 0; i < 16; i++) step({8'h60, i[2:0], 21'h0}, 19'h23DCF | {i[3], 14'h0});
    step(32'h5040_0000, 19'h17DD7);
    step(32'h5040_0000, 19'h57DD7);
    step(32'h4000_0000, 19'h087B9);
    step(32'h5000_0000, 19'h087B9);
    // Reset in mid-run while a live slot 0 access sits on the inputs
    i_addr = 32'h5040_0000;
    c = 19'h17DD7;
    i_srst = 1'b1;
    @(posedge i_clk);
    #1;
    check_reset();
    i_srst = 1'b0;
    step(32'h0, 19'h007FC);
    // Random traffic biased to the three windows; software widths drawn freely
    for (int n = 0; n < 3000; n++) begin
      rnd = xorshift(rnd);
      c = rnd[18:0] | {1'b0, rnd[27:25], 14'h0, rnd[24]};
      c[18] = &rnd[31:29];
      slow = rnd[23];
      rnd = xorshift(rnd);
      step(rnd[1:0] == 2'h3 ? rnd : {4'h4 + {2'h0, rnd[1:0]}, rnd[27:0]}, c);
    end
    final_report();
  end
endmodule // ext_bus_glue_tb
